// ===== pkg/rxdma_pkg.sv
// Shared constants and types for the receive status and DMA pointer block.
// Assumes an 8-bit register port and a byte-wide buffer memory port.
package rxdma_pkg;
   // Register byte offsets
   localparam logic [4:0] OFF_RING_FIRST = 5'h01;
   localparam logic [4:0] OFF_RING_LAST = 5'h02;
   localparam logic [4:0] OFF_RING_GUARD = 5'h03;
   localparam logic [4:0] OFF_TX_PAGE = 5'h04;
   localparam logic [4:0] OFF_TX_CNT_LO = 5'h05;
   localparam logic [4:0] OFF_TX_CNT_HI = 5'h06;
   localparam logic [4:0] OFF_RING_WRITE = 5'h07;
   localparam logic [4:0] OFF_LOCAL_LO = 5'h08;
   localparam logic [4:0] OFF_LOCAL_HI = 5'h09;
   localparam logic [4:0] OFF_RX_STATUS = 5'h0c;
   localparam logic [4:0] OFF_TALLY_ALIGN = 5'h0d;
   localparam logic [4:0] OFF_TALLY_CRC = 5'h0e;
   localparam logic [4:0] OFF_TALLY_MISS = 5'h0f;
   localparam logic [4:0] OFF_REM_START_LO = 5'h10;
   localparam logic [4:0] OFF_REM_START_HI = 5'h11;
   localparam logic [4:0] OFF_REM_CNT_LO = 5'h12;
   localparam logic [4:0] OFF_REM_CNT_HI = 5'h13;
   localparam logic [4:0] OFF_CONFIG = 5'h14;
   localparam logic [4:0] OFF_COMMAND = 5'h15;
   // Receive status bit positions
   localparam int ST_INTACT = 0;
   localparam int ST_CRC = 1;
   localparam int ST_ALIGN = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_MISSED = 4;
   localparam int ST_MATCH = 5;
   localparam int ST_DISABLED = 6;
   localparam int ST_DEFER = 7;
   // Config and command bit positions
   localparam int CFG_SAVE_ERR = 0;
   localparam int CFG_MONITOR = 1;
   localparam int CFG_WORD = 2;
   localparam int CMD_REMOTE = 0;
   localparam int CMD_TX = 1;
   // Pointer layout: status byte at page offset zero, data after it
   localparam logic [7:0] HEAD_OFFSET = 8'h00;
   localparam logic [7:0] DATA_OFFSET = 8'h01;
   localparam logic [7:0] PAGE_END = 8'hff;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   // Receive sequencer states
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_RECV = 3'b010,
      RX_STAT = 3'b100
   } rx_state_e;
   // One buffer memory cycle
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] data;
   } mem_req_s;
endpackage : rxdma_pkg

// ===== design/rx_status_dma.sv
// Receive status capture, tally counters, local and remote DMA pointers.
// Assumes receive event inputs come from logic on CLOCK; carrier and
// collision are raw pins; buffer memory takes one access every cycle.
// Function
// - Good packet status byte stored with packet
// - Errored status stored only when saving errors
// - Status cleared when next packet arrives
// - Internal tallies for CRC, alignment, missed
// - Intact flag only when error flags clear
// - CRC flag on CRC or alignment; tally
// - Alignment flag off-boundary bad CRC; tally
// - Overrun flag set and reception aborted
// - Missed flag on no buffers or monitor
// - Match type: physical zero, multicast one
// - Receiver disabled flag follows monitor mode
// - Deferring flag while carrier or collision
// - Good CRC few dribbles is no error
// - All registers are byte locations
// - Transmit start loads page, low byte zero
// - Full programmed count sent, never truncated
// - Ring bounded by first and last pages
// - Next page equal guard aborts local DMA
// - Write page restores pointers after errors
// - Local pointer readable as two bytes
// - Remote transfer from start and count
// - Remote step two for words, one bytes
// - Errored packets accepted only when saving
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rx_status_dma (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [4:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic RX_START,
   input wire logic RX_BYTE_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_END,
   input wire logic RX_CRC_BAD,
   input wire logic [2:0] RX_DRIBBLE,
   input wire logic RX_OVERRUN,
   input wire logic RX_MULTICAST,
   input wire logic CARRIER_SENSE,
   input wire logic COLLISION,
   output rxdma_pkg::mem_req_s MEM_REQ,
   output logic TX_BUSY,
   output logic REMOTE_BUSY
);
   // Ring page advance with wrap at the last page
   function automatic logic [7:0] next_page(input logic [7:0] page, input logic [7:0] first,
                                            input logic [7:0] last);
      logic [7:0] p;
      p = page + 8'h01;
      next_page = (p == last) ? first : p;
   endfunction : next_page

   // Countdown by step, stopping at zero
   function automatic logic [15:0] count_down(input logic [15:0] cnt, input logic [15:0] step);
      count_down = (cnt > step) ? cnt - step : '0;
   endfunction : count_down

   rxdma_pkg::rx_state_e rx_state_reg, rx_state_next; // Receive sequencer
   logic [7:0] ring_first_page_reg, ring_first_page_next;
   logic [7:0] ring_last_page_reg, ring_last_page_next;
   logic [7:0] ring_guard_page_reg, ring_guard_page_next;
   logic [7:0] ring_write_page_reg, ring_write_page_next;
   logic [7:0] transmit_page_start_reg, transmit_page_start_next;
   logic [15:0] transmit_count_reg, transmit_count_next; // Both count bytes
   logic [15:0] remote_start_reg, remote_start_next; // Both start bytes
   logic [15:0] remote_count_reg, remote_count_next; // Both count bytes
   logic [15:0] local_ptr_reg, local_ptr_next; // Shared local DMA address
   logic [15:0] tx_left_reg, tx_left_next; // Bytes still to fetch
   logic [15:0] rem_ptr_reg, rem_ptr_next; // Running remote address
   logic [15:0] rem_left_reg, rem_left_next; // Running remote count
   logic [7:0] status_reg, status_next; // Stored receive status
   logic [7:0] alignment_tally_reg, alignment_tally_next;
   logic [7:0] crc_tally_reg, crc_tally_next;
   logic [7:0] missed_tally_reg, missed_tally_next;
   logic [2:0] config_reg, config_next; // Save, monitor, word mode
   logic tx_busy_reg, tx_busy_next;
   logic rem_busy_reg, rem_busy_next;
   logic [2:0] sense_sync_reg, sense_sync_next; // Carrier or collision pin
   logic defer_reg, defer_next; // Filtered deferring level
   logic [7:0] rdata_reg, rdata_next;
   rxdma_pkg::mem_req_s mem_reg, mem_next;
   logic crc_err, align_err, pkt_err, rx_take, mem_busy; // Decode helpers
   logic [7:0] live_status;

   // Error decode for the ending packet
   always_comb begin
      crc_err = RX_CRC_BAD;
      align_err = RX_CRC_BAD && (RX_DRIBBLE != 3'h0);
      pkt_err = crc_err;
      rx_take = !config_reg[rxdma_pkg::CFG_MONITOR];
      // Status bits that track live levels rather than the packet
      live_status = status_reg;
      live_status[rxdma_pkg::ST_DISABLED] = config_reg[rxdma_pkg::CFG_MONITOR];
      live_status[rxdma_pkg::ST_DEFER] = defer_reg;
   end

   // Next-state logic for every register of the block
   always_comb begin
      rx_state_next = rx_state_reg;
      ring_first_page_next = ring_first_page_reg;
      ring_last_page_next = ring_last_page_reg;
      ring_guard_page_next = ring_guard_page_reg;
      ring_write_page_next = ring_write_page_reg;
      transmit_page_start_next = transmit_page_start_reg;
      transmit_count_next = transmit_count_reg;
      remote_start_next = remote_start_reg;
      remote_count_next = remote_count_reg;
      local_ptr_next = local_ptr_reg;
      tx_left_next = tx_left_reg;
      rem_ptr_next = rem_ptr_reg;
      rem_left_next = rem_left_reg;
      status_next = status_reg;
      alignment_tally_next = alignment_tally_reg;
      crc_tally_next = crc_tally_reg;
      missed_tally_next = missed_tally_reg;
      config_next = config_reg;
      tx_busy_next = tx_busy_reg;
      rem_busy_next = rem_busy_reg;
      mem_next = '0;
      mem_busy = 1'b0;
      rdata_next = '0;
      // Pin filter: a change counts once the later two stages agree
      sense_sync_next = {sense_sync_reg[1:0], CARRIER_SENSE | COLLISION};
      defer_next = (sense_sync_reg[2] == sense_sync_reg[1]) ? sense_sync_reg[2] : defer_reg;
      // Byte-wide register writes
      if (REG_WR) begin
         case (REG_ADDR)
            rxdma_pkg::OFF_RING_FIRST: ring_first_page_next = REG_WDATA;
            rxdma_pkg::OFF_RING_LAST: ring_last_page_next = REG_WDATA;
            rxdma_pkg::OFF_RING_GUARD: ring_guard_page_next = REG_WDATA;
            rxdma_pkg::OFF_RING_WRITE: ring_write_page_next = REG_WDATA;
            rxdma_pkg::OFF_TX_PAGE: transmit_page_start_next = REG_WDATA;
            rxdma_pkg::OFF_TX_CNT_LO: transmit_count_next[7:0] = REG_WDATA;
            rxdma_pkg::OFF_TX_CNT_HI: transmit_count_next[15:8] = REG_WDATA;
            rxdma_pkg::OFF_REM_START_LO: remote_start_next[7:0] = REG_WDATA;
            rxdma_pkg::OFF_REM_START_HI: remote_start_next[15:8] = REG_WDATA;
            rxdma_pkg::OFF_REM_CNT_LO: remote_count_next[7:0] = REG_WDATA;
            rxdma_pkg::OFF_REM_CNT_HI: remote_count_next[15:8] = REG_WDATA;
            rxdma_pkg::OFF_CONFIG: config_next = REG_WDATA[2:0];
            rxdma_pkg::OFF_COMMAND: begin
               // Start remote block transfer from its programmed window
               if (REG_WDATA[rxdma_pkg::CMD_REMOTE] && remote_count_reg != 16'h0000) begin
                  rem_busy_next = 1'b1;
                  rem_ptr_next = remote_start_reg;
                  rem_left_next = remote_count_reg;
               end
               // Start transmit fetch at the page boundary
               if (REG_WDATA[rxdma_pkg::CMD_TX] && transmit_count_reg != 16'h0000) begin
                  tx_busy_next = 1'b1;
                  local_ptr_next = {transmit_page_start_reg, 8'h00};
                  tx_left_next = transmit_count_reg;
               end
            end
            default: ; // Unmapped writes are dropped
         endcase
      end
      // Byte-wide register reads, data valid in the next cycle only
      if (REG_RD) begin
         case (REG_ADDR)
            rxdma_pkg::OFF_RING_FIRST: rdata_next = ring_first_page_reg;
            rxdma_pkg::OFF_RING_LAST: rdata_next = ring_last_page_reg;
            rxdma_pkg::OFF_RING_GUARD: rdata_next = ring_guard_page_reg;
            rxdma_pkg::OFF_RING_WRITE: rdata_next = ring_write_page_reg;
            rxdma_pkg::OFF_TX_PAGE: rdata_next = transmit_page_start_reg;
            rxdma_pkg::OFF_TX_CNT_LO: rdata_next = transmit_count_reg[7:0];
            rxdma_pkg::OFF_TX_CNT_HI: rdata_next = transmit_count_reg[15:8];
            rxdma_pkg::OFF_LOCAL_LO: rdata_next = local_ptr_reg[7:0];
            rxdma_pkg::OFF_LOCAL_HI: rdata_next = local_ptr_reg[15:8];
            rxdma_pkg::OFF_RX_STATUS: rdata_next = live_status;
            rxdma_pkg::OFF_TALLY_ALIGN: rdata_next = alignment_tally_reg;
            rxdma_pkg::OFF_TALLY_CRC: rdata_next = crc_tally_reg;
            rxdma_pkg::OFF_TALLY_MISS: rdata_next = missed_tally_reg;
            rxdma_pkg::OFF_REM_START_LO: rdata_next = remote_start_reg[7:0];
            rxdma_pkg::OFF_REM_START_HI: rdata_next = remote_start_reg[15:8];
            rxdma_pkg::OFF_REM_CNT_LO: rdata_next = remote_count_reg[7:0];
            rxdma_pkg::OFF_REM_CNT_HI: rdata_next = remote_count_reg[15:8];
            rxdma_pkg::OFF_CONFIG: rdata_next = {5'h00, config_reg};
            rxdma_pkg::OFF_COMMAND: rdata_next = {6'h00, tx_busy_reg, rem_busy_reg};
            default: rdata_next = '0; // Unmapped reads give zero
         endcase
      end
      // Receive sequencer; it owns memory ahead of transmit and remote
      case (rx_state_reg)
         rxdma_pkg::RX_IDLE: begin
            if (RX_START) begin
               status_next = '0;
               rx_state_next = rxdma_pkg::RX_RECV;
               local_ptr_next = {ring_write_page_reg, rxdma_pkg::DATA_OFFSET};
            end
         end
         rxdma_pkg::RX_RECV: begin
            if (RX_OVERRUN) begin
               // Abort and fall back to the saved first page
               status_next[rxdma_pkg::ST_OVERRUN] = 1'b1;
               local_ptr_next = {ring_write_page_reg, rxdma_pkg::HEAD_OFFSET};
               rx_state_next = rxdma_pkg::RX_IDLE;
            end else if (RX_END) begin
               status_next[rxdma_pkg::ST_CRC] = crc_err;
               status_next[rxdma_pkg::ST_ALIGN] = align_err;
               status_next[rxdma_pkg::ST_MATCH] = RX_MULTICAST;
               status_next[rxdma_pkg::ST_MISSED] = !rx_take;
               status_next[rxdma_pkg::ST_INTACT] = !crc_err && rx_take;
               if (crc_err) begin
                  crc_tally_next = crc_tally_reg + 8'h01;
               end
               if (align_err) begin
                  alignment_tally_next = alignment_tally_reg + 8'h01;
               end
               if (!rx_take) begin
                  missed_tally_next = missed_tally_reg + 8'h01;
               end
               // Store status only for kept packets
               if (rx_take && (!pkt_err || config_reg[rxdma_pkg::CFG_SAVE_ERR])) begin
                  rx_state_next = rxdma_pkg::RX_STAT;
               end else begin
                  local_ptr_next = {ring_write_page_reg, rxdma_pkg::HEAD_OFFSET};
                  rx_state_next = rxdma_pkg::RX_IDLE;
               end
            end else if (RX_BYTE_VALID && rx_take) begin
               mem_busy = 1'b1;
               mem_next = '{valid: 1'b1, write: 1'b1, addr: local_ptr_reg, data: RX_BYTE};
               if (local_ptr_reg[7:0] == rxdma_pkg::PAGE_END) begin
                  // Page crossing: stop short of the page software still owns
                  if (next_page(local_ptr_reg[15:8], ring_first_page_reg, ring_last_page_reg)
                      == ring_guard_page_reg) begin
                     status_next[rxdma_pkg::ST_MISSED] = 1'b1;
                     missed_tally_next = missed_tally_reg + 8'h01;
                     local_ptr_next = {ring_write_page_reg, rxdma_pkg::HEAD_OFFSET};
                     rx_state_next = rxdma_pkg::RX_IDLE;
                  end else begin
                     local_ptr_next = {next_page(local_ptr_reg[15:8], ring_first_page_reg,
                                                 ring_last_page_reg), 8'h00};
                  end
               end else begin
                  local_ptr_next = local_ptr_reg + rxdma_pkg::STEP_BYTE;
               end
            end
         end
         rxdma_pkg::RX_STAT: begin
            // Status byte goes to the head of the packet's first page
            mem_busy = 1'b1;
            mem_next = '{valid: 1'b1, write: 1'b1,
                         addr: {ring_write_page_reg, rxdma_pkg::HEAD_OFFSET}, data: status_reg};
            ring_write_page_next = next_page(local_ptr_reg[15:8], ring_first_page_reg,
                                             ring_last_page_reg);
            rx_state_next = rxdma_pkg::RX_IDLE;
         end
         default: rx_state_next = rxdma_pkg::RX_IDLE;
      endcase
      // Transmit fetch runs only while receive is idle and memory free
      if (tx_busy_reg && !mem_busy && rx_state_reg == rxdma_pkg::RX_IDLE && !RX_START) begin
         mem_busy = 1'b1;
         mem_next = '{valid: 1'b1, write: 1'b0, addr: local_ptr_reg, data: 8'h00};
         local_ptr_next = local_ptr_reg + rxdma_pkg::STEP_BYTE;
         tx_left_next = count_down(tx_left_reg, rxdma_pkg::STEP_BYTE);
         tx_busy_next = (tx_left_reg != rxdma_pkg::STEP_BYTE);
      end
      // Remote block read takes whatever cycles remain
      if (rem_busy_reg && !mem_busy) begin
         mem_next = '{valid: 1'b1, write: 1'b0, addr: rem_ptr_reg, data: 8'h00};
         if (config_reg[rxdma_pkg::CFG_WORD]) begin
            rem_ptr_next = rem_ptr_reg + rxdma_pkg::STEP_WORD;
            rem_left_next = count_down(rem_left_reg, rxdma_pkg::STEP_WORD);
            rem_busy_next = (rem_left_reg > rxdma_pkg::STEP_WORD);
         end else begin
            rem_ptr_next = rem_ptr_reg + rxdma_pkg::STEP_BYTE;
            rem_left_next = count_down(rem_left_reg, rxdma_pkg::STEP_BYTE);
            rem_busy_next = (rem_left_reg > rxdma_pkg::STEP_BYTE);
         end
      end
   end

   // State registers only
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rx_state_reg <= rxdma_pkg::RX_IDLE;
         ring_first_page_reg <= '0;
         ring_last_page_reg <= '0;
         ring_guard_page_reg <= '0;
         ring_write_page_reg <= '0;
         transmit_page_start_reg <= '0;
         transmit_count_reg <= '0;
         remote_start_reg <= '0;
         remote_count_reg <= '0;
         local_ptr_reg <= '0;
         tx_left_reg <= '0;
         rem_ptr_reg <= '0;
         rem_left_reg <= '0;
         status_reg <= '0;
         alignment_tally_reg <= '0;
         crc_tally_reg <= '0;
         missed_tally_reg <= '0;
         config_reg <= '0;
         tx_busy_reg <= 1'b0;
         rem_busy_reg <= 1'b0;
         sense_sync_reg <= '0;
         defer_reg <= 1'b0;
         rdata_reg <= '0;
         mem_reg <= '0;
      end else begin
         rx_state_reg <= rx_state_next;
         ring_first_page_reg <= ring_first_page_next;
         ring_last_page_reg <= ring_last_page_next;
         ring_guard_page_reg <= ring_guard_page_next;
         ring_write_page_reg <= ring_write_page_next;
         transmit_page_start_reg <= transmit_page_start_next;
         transmit_count_reg <= transmit_count_next;
         remote_start_reg <= remote_start_next;
         remote_count_reg <= remote_count_next;
         local_ptr_reg <= local_ptr_next;
         tx_left_reg <= tx_left_next;
         rem_ptr_reg <= rem_ptr_next;
         rem_left_reg <= rem_left_next;
         status_reg <= status_next;
         alignment_tally_reg <= alignment_tally_next;
         crc_tally_reg <= crc_tally_next;
         missed_tally_reg <= missed_tally_next;
         config_reg <= config_next;
         tx_busy_reg <= tx_busy_next;
         rem_busy_reg <= rem_busy_next;
         sense_sync_reg <= sense_sync_next;
         defer_reg <= defer_next;
         rdata_reg <= rdata_next;
         mem_reg <= mem_next;
      end
   end

   // Outputs straight from flip-flops
   assign REG_RDATA = rdata_reg;
   assign MEM_REQ = mem_reg;
   assign TX_BUSY = tx_busy_reg;
   assign REMOTE_BUSY = rem_busy_reg;

   // Checks on the receive path and pointers
   stat_write_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      rx_state_reg == rxdma_pkg::RX_STAT |=> MEM_REQ.valid && MEM_REQ.write
      && MEM_REQ.addr == {$past(ring_write_page_reg), rxdma_pkg::HEAD_OFFSET} && MEM_REQ.data == $past(status_reg))
      else $error("status byte not written to packet head");
   reject_nostat_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      rx_state_reg == rxdma_pkg::RX_RECV && !RX_OVERRUN && RX_END && RX_CRC_BAD
      && !config_reg[rxdma_pkg::CFG_SAVE_ERR] |=> rx_state_reg == rxdma_pkg::RX_IDLE ##1 !MEM_REQ.write)
      else $error("rejected packet status was stored");
   arrive_clear_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      rx_state_reg == rxdma_pkg::RX_IDLE && RX_START |=> status_reg == 8'h00)
      else $error("status not cleared on arrival");
   intact_excl_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      status_reg[rxdma_pkg::ST_INTACT] |-> status_reg[4:1] == 4'h0)
      else $error("intact flag with error flag");
   align_crc_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      status_reg[rxdma_pkg::ST_ALIGN] |-> status_reg[rxdma_pkg::ST_CRC])
      else $error("alignment error without crc error");
   crc_tally_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      rx_state_reg == rxdma_pkg::RX_RECV && !RX_OVERRUN && RX_END && RX_CRC_BAD
      |=> crc_tally_reg == $past(crc_tally_reg) + 8'h01)
      else $error("crc tally not incremented");
   tx_load_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      $rose(tx_busy_reg) |-> local_ptr_reg == {transmit_page_start_reg, 8'h00} ##1 MEM_REQ.addr[7:0] == 8'h00
      || !MEM_REQ.valid || MEM_REQ.write)
      else $error("transmit pointer not page aligned");
   remote_step_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      rem_busy_reg && MEM_REQ.valid && !MEM_REQ.write && MEM_REQ.addr == $past(rem_ptr_reg)
      && config_reg[rxdma_pkg::CFG_WORD] && $stable(config_reg) && rem_busy_reg
      |-> rem_ptr_reg == MEM_REQ.addr + rxdma_pkg::STEP_WORD)
      else $error("remote word step not two");
   defer_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      sense_sync_reg[2] && sense_sync_reg[1] |=> defer_reg)
      else $error("deferring flag not following sense");
   cover_good_c: cover property (@(posedge CLOCK) disable iff (SYS_RST)
      rx_state_reg == rxdma_pkg::RX_STAT && status_reg[rxdma_pkg::ST_INTACT]);
   cover_wrap_c: cover property (@(posedge CLOCK) disable iff (SYS_RST)
      rx_state_reg == rxdma_pkg::RX_RECV && local_ptr_reg[15:8] == ring_first_page_reg
      && $past(local_ptr_reg[7:0]) == rxdma_pkg::PAGE_END);
   cover_remote_c: cover property (@(posedge CLOCK) disable iff (SYS_RST) $fell(rem_busy_reg));
   cover_tx_c: cover property (@(posedge CLOCK) disable iff (SYS_RST) $fell(tx_busy_reg));
endmodule : rx_status_dma
`default_nettype wire

// ===== test/buf_mem.sv
// Buffer memory model on the system bus side of the block.
// Assumes one registered request per cycle; it never stalls.
`timescale 1ns/1ps
`default_nettype none
module buf_mem (
   input wire logic CLOCK,
   input wire rxdma_pkg::mem_req_s req
);
   logic [7:0] mem [logic [15:0]]; // Sparse byte store
   logic [15:0] rdq [$]; // Read addresses, oldest first
   // Accept every request at once
   always @(posedge CLOCK) begin
      if (req.valid && req.write) mem[req.addr] = req.data;
      else if (req.valid) rdq.push_back(req.addr);
   end
endmodule : buf_mem
`default_nettype wire

// ===== test/testbench.sv
// Bench: register tasks, received packets and remote reads.
// Assumes buf_mem answers every cycle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic CLOCK = '0, SYS_RST = '1, REG_WR = '0, REG_RD = '0, RX_START = '0, RX_BYTE_VALID = '0;
   logic RX_END = '0, RX_CRC_BAD = '0, RX_MULTICAST = '0, CARRIER_SENSE = '0, TX_BUSY, REMOTE_BUSY;
   logic RX_OVERRUN = '0, COLLISION = '0;
   logic [4:0] REG_ADDR = '0;
   logic [7:0] REG_WDATA = '0, REG_RDATA, RX_BYTE = '0;
   logic [2:0] RX_DRIBBLE = '0;
   rxdma_pkg::mem_req_s mem_req;
   int n_errors = 0, checks = 0, i;
   always #25 CLOCK = ~CLOCK; // 20 MHz
   rx_status_dma dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_START(RX_START),
      .RX_BYTE_VALID(RX_BYTE_VALID), .RX_BYTE(RX_BYTE), .RX_END(RX_END), .RX_CRC_BAD(RX_CRC_BAD),
      .RX_DRIBBLE(RX_DRIBBLE), .RX_OVERRUN(RX_OVERRUN), .RX_MULTICAST(RX_MULTICAST),
      .CARRIER_SENSE(CARRIER_SENSE), .COLLISION(COLLISION), .MEM_REQ(mem_req), .TX_BUSY(TX_BUSY),
      .REMOTE_BUSY(REMOTE_BUSY));
   buf_mem mem (.CLOCK(CLOCK), .req(mem_req));
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One strobe cycle, write or read
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      REG_WR <= w;
      REG_RD <= !w;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLOCK);
      REG_WR <= 1'h0;
      REG_RD <= 1'h0;
   endtask : bus
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      bus(1'h0, a, 8'h00);
      #1 chk(REG_RDATA, exp);
   endtask : rd
   // Wait off the edge until both fetch engines drain, then one edge for the last request
   task automatic settle;
      #1;
      for (i = 0; i < 50 && (REMOTE_BUSY | TX_BUSY) !== 1'h0; i++) begin
         @(posedge CLOCK);
         #1;
      end
      chk(i < 50, 16'h0001);
      if (i >= 50) stop_test();
      @(posedge CLOCK);
      #1;
   endtask : settle
   // One packet of n bytes counting up from b
   task automatic rx(input logic [7:0] b, input logic crc, input logic [2:0] drib, input logic mc, input int n);
      @(posedge CLOCK) RX_START <= 1'h1;
      @(posedge CLOCK) RX_START <= 1'h0;
      RX_BYTE_VALID <= 1'h1;
      RX_BYTE <= b;
      repeat (n - 1) @(posedge CLOCK) RX_BYTE <= RX_BYTE + 8'h01;
      @(posedge CLOCK) RX_BYTE_VALID <= 1'h0;
      {RX_END, RX_CRC_BAD, RX_DRIBBLE, RX_MULTICAST} <= {1'h1, crc, drib, mc};
      @(posedge CLOCK) RX_END <= 1'h0;
      repeat (4) @(posedge CLOCK);
   endtask : rx
   task automatic stop_test;
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   initial begin
      repeat (12) @(posedge CLOCK);
      SYS_RST <= 1'h0;
      rd(5'h0c, 8'h00);
      rd(5'h1f, 8'h00);
      bus(1'h1, 5'h01, 8'h40);
      bus(1'h1, 5'h02, 8'h50);
      bus(1'h1, 5'h03, 8'h4f);
      bus(1'h1, 5'h07, 8'h40);
      rd(5'h02, 8'h50);
      rx(8'ha5, 1'h0, 3'h3, 1'h1, 1);
      chk(mem.mem[16'h4001], 16'h00a5);
      chk(mem.mem[16'h4000], 16'h0021);
      rx(8'h5a, 1'h1, 3'h1, 1'h0, 1);
      rd(5'h0c, 8'h06);
      chk(mem.mem.exists(16'h4100), 16'h0000);
      rd(5'h0d, 8'h01);
      rd(5'h0e, 8'h01);
      bus(1'h1, 5'h14, 8'h02);
      COLLISION <= 1'h1;
      repeat (4) @(posedge CLOCK);
      rd(5'h0c, 8'hc6);
      {CARRIER_SENSE, COLLISION} <= 2'h2;
      repeat (4) @(posedge CLOCK);
      rd(5'h0c, 8'hc6);
      CARRIER_SENSE <= 1'h0;
      rx(8'h11, 1'h0, 3'h0, 1'h0, 1);
      rd(5'h0f, 8'h01);
      bus(1'h1, 5'h14, 8'h04);
      bus(1'h1, 5'h02, 8'h42);
      rx(8'h00, 1'h0, 3'h0, 1'h0, 256);
      chk(mem.mem[16'h41ff], 16'h00fe);
      chk(mem.mem[16'h4000], 16'h00ff);
      chk(mem.mem[16'h4100], 16'h0001);
      rd(5'h07, 8'h41);
      bus(1'h1, 5'h03, 8'h40);
      rx(8'h00, 1'h0, 3'h0, 1'h0, 256);
      rd(5'h0c, 8'h10);
      rd(5'h0f, 8'h02);
      @(posedge CLOCK) RX_START <= 1'h1;
      @(posedge CLOCK) RX_START <= 1'h0;
      RX_OVERRUN <= 1'h1;
      @(posedge CLOCK) RX_OVERRUN <= 1'h0;
      rd(5'h0c, 8'h08);
      rd(5'h08, 8'h00);
      rd(5'h09, 8'h41);
      bus(1'h1, 5'h10, 8'h34);
      bus(1'h1, 5'h11, 8'h12);
      bus(1'h1, 5'h12, 8'h04);
      bus(1'h1, 5'h14, 8'h04);
      bus(1'h1, 5'h15, 8'h01);
      settle();
      chk(REMOTE_BUSY, 16'h0000);
      chk(mem.rdq.size(), 16'h0002);
      chk(mem.rdq[1] - mem.rdq[0], 16'h0002);
      chk(mem.rdq[0], 16'h1234);
      bus(1'h1, 5'h04, 8'h60);
      bus(1'h1, 5'h05, 8'h03);
      bus(1'h1, 5'h15, 8'h02);
      #1 chk(TX_BUSY, 16'h0001);
      settle();
      chk(TX_BUSY, 16'h0000);
      chk(mem.rdq.size(), 16'h0005);
      chk(mem.rdq[2], 16'h6000);
      chk(mem.rdq[4], 16'h6002);
      rd(5'h08, 8'h03);
      rd(5'h09, 8'h60);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
